//--- logic/pstat_consts.svh
// Offsets, field positions and reset values of the core status word.
// Assumes inclusion by the main module only.
`ifndef PSTAT_CONSTS_SVH
`define PSTAT_CONSTS_SVH

`define PSTAT_OFF_STATUS    12'h0D0
`define PSTAT_OFF_ACC       12'h0D4
`define PSTAT_STATUS_RESET  8'h00
`define PSTAT_BIT_CARRY     7
`define PSTAT_BIT_AUX       6
`define PSTAT_BIT_USER0     5
`define PSTAT_BIT_BANK_HI   4
`define PSTAT_BIT_BANK_LO   3
`define PSTAT_BIT_EXCESS    2
`define PSTAT_BIT_USER1     1
`define PSTAT_BIT_PARITY    0
`define PSTAT_BANK_SHIFT    3

`endif

//--- logic/pstat_parity.sv
// Even-parity flag from the accumulator.
// Assumes a purely combinational use in the main block.
`timescale 1ns/1ps
module pstat_parity #(
    parameter int WIDTH = 8
) (
    input  wire logic [WIDTH-1:0] accValue,
    output logic                  evenOnes
);
    logic [WIDTH:0] chain;

    assign chain[0] = 1'b1;
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_par
            assign chain[i+1] = chain[i] ^ accValue[i];
        end
    endgenerate
    assign evenOnes = chain[WIDTH];
endmodule : pstat_parity

//--- logic/pstat_pkg.sv
// Types shared by the status word block.
// Assumes the consts header sits beside it.
package pstat_pkg;

    // ********************
    // Status word layout
    // ********************
    typedef struct packed {
        logic       carryFlag;
        logic       auxCarryFlag;
        logic       userFlagZero;
        logic [1:0] bankSelect;
        logic       signedExcessFlag;
        logic       userFlagOne;
        logic       parityFlag;
    } pstat_word_s;

    // Flag update from the core datapath
    typedef struct packed {
        logic carryWe;
        logic carry;
        logic auxWe;
        logic aux;
        logic excessWe;
        logic excess;
    } pstat_alu_s;

endpackage : pstat_pkg

//--- logic/pstat_status_word.sv
// Core status word: flags, bank select and parity, behind an APB slave.
// Assumes the core supplies accumulator value and ALU flag updates each cycle.
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "pstat_consts.svh"
module pstat_status_word
    import pstat_pkg::*;
#(
    parameter int ACC_WIDTH = 8
) (
    input  wire logic                 clk_sys,
    input  wire logic                 rst,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic [ACC_WIDTH-1:0] accValue,
    input  wire pstat_alu_s           aluUpdate,
    output pstat_word_s               statusWord,
    output logic      [4:0]           bankBase
);

    // ********************
    // Register state
    // ********************
    pstat_word_s status_reg;
    logic        parityNow;
    logic        setupHit;
    logic        wrStatus;

    pstat_parity #(
        .WIDTH (ACC_WIDTH)
    ) u_parity (
        .accValue (accValue),
        .evenOnes (parityNow)
    );

    assign setupHit = psel && !penable;
    assign wrStatus = psel && penable && pready && pwrite
                      && (paddr == `PSTAT_OFF_STATUS);

    // Flags; ALU update wins over a software write in the same cycle
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            status_reg <= pstat_word_s'(`PSTAT_STATUS_RESET);
        end else begin
            if (wrStatus) begin
                status_reg.userFlagZero <= pwdata[`PSTAT_BIT_USER0];
                status_reg.bankSelect   <= pwdata[`PSTAT_BIT_BANK_HI:`PSTAT_BIT_BANK_LO];
                status_reg.userFlagOne  <= pwdata[`PSTAT_BIT_USER1];
                status_reg.carryFlag        <= pwdata[`PSTAT_BIT_CARRY];
                status_reg.auxCarryFlag     <= pwdata[`PSTAT_BIT_AUX];
                status_reg.signedExcessFlag <= pwdata[`PSTAT_BIT_EXCESS];
            end
            if (aluUpdate.carryWe) begin
                status_reg.carryFlag <= aluUpdate.carry;
            end
            if (aluUpdate.auxWe) begin
                status_reg.auxCarryFlag <= aluUpdate.aux;
            end
            if (aluUpdate.excessWe) begin
                status_reg.signedExcessFlag <= aluUpdate.excess;
            end
            // Parity is read-only, always tracks the accumulator
            status_reg.parityFlag <= parityNow;
        end
    end

    // ********************
    // Outputs to the core
    // ********************
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            statusWord <= pstat_word_s'(`PSTAT_STATUS_RESET);
            bankBase   <= 5'h00;
        end else begin
            statusWord <= status_reg;
            bankBase   <= {status_reg.bankSelect, 3'h0};
        end
    end

    // ********************
    // APB slave, no wait states
    // ********************
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= setupHit;
            pslverr <= 1'b0;
            if (setupHit) begin
                unique case (paddr)
                    `PSTAT_OFF_STATUS: prdata <= {24'h000000, status_reg};
                    `PSTAT_OFF_ACC:    prdata <= 32'(accValue);
                    default: begin
                        prdata  <= 32'h00000000;
                        pslverr <= 1'b1;
                    end
                endcase
            end else begin
                prdata <= 32'h00000000;
            end
        end
    end

endmodule : pstat_status_word

//--- test/pstat_core_model.sv
// Core datapath stand-in: accumulator and flag strobes.
// Assumes calls just after a rising clock edge.
`timescale 1ns/1ps
module pstat_core_model
    import pstat_pkg::*;
(
    output logic [7:0] accValue,
    output pstat_alu_s aluUpdate
);
    // Odd start value, so parity reads zero after reset
    initial accValue = 8'h01;
    initial aluUpdate = '0;
    task automatic drive(input logic [7:0] a, input pstat_alu_s u);
        accValue <= a;
        aluUpdate <= u;
    endtask : drive
endmodule : pstat_core_model

//--- test/pstat_status_word_sva.sv
// Checker on the status word ports.
// Assumes binding onto the status word block.
`timescale 1ns/1ps
module pstat_status_word_sva
    import pstat_pkg::*;
#(
    parameter int ACC_WIDTH = 8
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pready,
    input wire logic [ACC_WIDTH-1:0] accValue,
    input wire pstat_alu_s aluUpdate,
    input wire pstat_word_s statusWord,
    input wire logic [4:0] bankBase
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Both outputs load from the same internal register at the same edge
    property p_bank; bankBase == {statusWord.bankSelect, 3'h0}; endproperty
    a_bank: assert property (p_bank) else $error("bank base");
    // Skip edges whose parity stage was still in reset
    property p_par; !$past(rst) && !$past(rst, 2) |->
        statusWord.parityFlag == ~^$past(accValue, 2); endproperty
    a_par: assert property (p_par) else $error("parity");
    property p_usr; !$stable(statusWord.userFlagZero) |->
        $past(psel && penable && pready && pwrite, 2); endproperty
    a_usr: assert property (p_usr) else $error("user flag");
    property p_rst; disable iff (1'b0) rst [*2] |->
        statusWord == 8'h00 && bankBase == 5'h00 && !pready; endproperty
    a_rst: assert property (p_rst) else $error("reset");
    property p_cy; aluUpdate.carryWe |->
        ##2 statusWord.carryFlag == $past(aluUpdate.carry, 2); endproperty
    a_cy: assert property (p_cy) else $error("carry");
endmodule : pstat_status_word_sva
bind pstat_status_word pstat_status_word_sva #(.ACC_WIDTH(ACC_WIDTH)) u_sva (.*);

//--- test/tb.sv
// Self-checking bench for the status word.
// Assumes design, core model and checker compiled first.
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_mismatch++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb
    import pstat_pkg::*;
;
    logic clk_sys = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err;
    logic [7:0] accValue;
    logic [4:0] bankBase;
    pstat_alu_s aluUpdate;
    pstat_word_s statusWord;
    int n_mismatch = 0, cmp_count = 0;
    always #25 clk_sys = ~clk_sys;
    pstat_status_word u_dut (.*);
    pstat_core_model u_core (.*);
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int t;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        for (t = 0; t < 20 && pready !== 1'b1; t++) @(posedge clk_sys);
        if (t == 20) n_mismatch++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic t_reset;
        apb(1'b0, 12'h0D0, 32'h0);
        `CHK(rd, 32'h0000_0000)
        apb(1'b0, 12'h0FC, 32'h0);
        `CHK({err, rd}, 33'h1_0000_0000)
    endtask : t_reset
    task automatic t_bank;
        for (int b = 0; b < 4; b++) begin
            apb(1'b1, 12'h0D0, 32'(b * 8));
            repeat (3) @(posedge clk_sys);
            `CHK(bankBase, 5'(b * 8))
        end
    endtask : t_bank
    task automatic t_par;
        for (int i = 0; i < 4; i++) begin
            u_core.drive(8'(8'hFF >> i), '0);
            apb(1'b0, 12'h0D0, 32'h0);
            `CHK(rd[0], ~^(8'hFF >> i))
        end
    endtask : t_par
    task automatic t_flags;
        u_core.drive(8'h01, pstat_alu_s'(6'h30));
        @(posedge clk_sys);
        u_core.drive(8'h01, '0);
        apb(1'b0, 12'h0D0, 32'h0);
        `CHK(rd, 32'h0000_0098)
        apb(1'b1, 12'h0D0, 32'hFFFF_FF22);
        apb(1'b0, 12'h0D0, 32'h0);
        `CHK(rd, 32'h0000_0022)
        `CHK(statusWord, 8'h22)
        u_core.drive(8'h01, pstat_alu_s'(6'h0F));
        @(posedge clk_sys);
        u_core.drive(8'h01, '0);
        apb(1'b0, 12'h0D0, 32'h0);
        `CHK(rd, 32'h0000_0066)
        apb(1'b0, 12'h0D4, 32'h0);
        `CHK(rd, 32'h0000_0001)
    endtask : t_flags
    task automatic stop_test;
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : stop_test
    initial begin
        #100000;
        n_mismatch++;
        stop_test();
    end
    initial begin
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        t_reset();
        t_bank();
        t_par();
        t_flags();
        stop_test();
    end
endmodule : tb
